// ==== rtl/wtc_defines.vh ====
// register map, field positions and encodings for the weight target comparator
`ifndef WTC_DEFINES_VH
`define WTC_DEFINES_VH

`define WTC_A_CTRL     4'h0
`define WTC_A_TARGET   4'h1
`define WTC_A_POSTOL   4'h2
`define WTC_A_NEGTOL   4'h3
`define WTC_A_SPILL    4'h4
`define WTC_A_FINE     4'h5
`define WTC_A_CMD      4'h6
`define WTC_A_TBL_IDX  4'h7
`define WTC_A_TBL_DATA 4'h8
`define WTC_A_STATUS   4'h9

`define WTC_MODE_NONE  2'h0
`define WTC_MODE_MT    2'h1
`define WTC_MODE_OU    2'h2

`define WTC_TOL_DEV    2'h0
`define WTC_TOL_PCT    2'h1
`define WTC_TOL_WV     2'h2

`define WTC_C_MODE_LO  0
`define WTC_C_TOL_LO   2
`define WTC_C_INDEP    4
`define WTC_C_SRC      5
`define WTC_C_LATCH    6
`define WTC_C_MOTION   7

`define WTC_K_START    0
`define WTC_K_RECALL   1
`define WTC_K_STORE    2
`define WTC_K_CLEAR    3

`define WTC_PCT_DIV    32'd100
`define WTC_CTRL_RST   32'h0000_0000

`endif

// ==== rtl/wtc_top.v ====
// weight target comparator with avalon-mm register slave
`timescale 1ns/1ps
`include "wtc_defines.vh"

module wtc_top #(
	parameter W       = 32,
	parameter TBL_N   = 16,
	parameter TBL_AW  = 4
) (
	input  wire          CORE_CLK,
	input  wire          RST,
	input  wire [3:0]    AVS_ADDRESS,
	input  wire          AVS_READ,
	input  wire          AVS_WRITE,
	input  wire [31:0]   AVS_WRITEDATA,
	input  wire [3:0]    AVS_BYTEENABLE,
	output reg  [31:0]   AVS_READDATA,
	output wire          AVS_WAITREQUEST,
	input  wire [W-1:0]  GROSS_WEIGHT,
	input  wire [W-1:0]  DISP_WEIGHT,
	input  wire          MOTION,
	input  wire          START_IN,
	output reg           FAST_FEED,
	output reg           SLOW_FEED,
	output reg           OVER_ZONE,
	output reg           TOL_OK,
	output reg           UNDER_ZONE
);

	// byte-enable merge of a 32-bit word
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer k;
		begin
			be_merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k])
					be_merge[k*8 +: 8] = nw[k*8 +: 8];
			end
		end
	endfunction

	// percent of target, or the absolute value
	function [W-1:0] tol_eff;
		input [W-1:0] tgt;
		input [W-1:0] tol;
		input         pct;
		reg   [2*W-1:0] prod;
		begin
			// divide the full product so large targets do not wrap
			prod = (tgt * tol) / `WTC_PCT_DIV;
			if (pct)
				tol_eff = prod[W-1:0];
			else
				tol_eff = tol;
		end
	endfunction

	// saturating subtraction
	function [W-1:0] sat_sub;
		input [W-1:0] a;
		input [W-1:0] b;
		begin
			sat_sub = (a > b) ? (a - b) : {W{1'b0}};
		end
	endfunction

	// saturating addition, pins at all ones instead of wrapping
	function [W-1:0] sat_add;
		input [W-1:0] a;
		input [W-1:0] b;
		reg   [W:0]   s;
		begin
			s = {1'b0, a} + {1'b0, b};
			sat_add = s[W] ? {W{1'b1}} : s[W-1:0];
		end
	endfunction

	// control and active record registers
	reg  [31:0] ctrl_r;                    // mode, tol type, out type, src, latch, motion
	reg  [W-1:0] target_r;                 // active target
	reg  [W-1:0] postol_r;                 // positive tol or over limit
	reg  [W-1:0] negtol_r;                 // negative tol or under limit
	reg  [W-1:0] spill_r;                  // spill after stop
	reg  [W-1:0] fine_r;                   // fine feed point
	reg  [TBL_AW-1:0] idx_r;               // table entry pointer
	reg  [2:0]   sel_r;                    // table word select
	// stored target table, five words per entry
	reg  [W-1:0] tbl_tgt [0:TBL_N-1];
	reg  [W-1:0] tbl_pos [0:TBL_N-1];
	reg  [W-1:0] tbl_neg [0:TBL_N-1];
	reg  [W-1:0] tbl_spl [0:TBL_N-1];
	reg  [W-1:0] tbl_fin [0:TBL_N-1];
	// start input synchroniser, three stages
	reg  [2:0]   start_sync_r;
	reg          start_lvl_r;              // filtered level
	reg          start_lvl_d_r;            // previous filtered level
	reg  [2:0]   mot_sync_r;
	reg          mot_lvl_r;
	reg          latch_r;                  // outputs held off
	reg          fast_done_r;              // fast feed cutoff passed
	reg          ack_r;                    // one-cycle answer pulse
	integer      i;

	wire [1:0] mode    = ctrl_r[`WTC_C_MODE_LO +: 2];
	wire [1:0] toltype = ctrl_r[`WTC_C_TOL_LO +: 2];
	wire       indep   = ctrl_r[`WTC_C_INDEP];
	wire       src_disp = ctrl_r[`WTC_C_SRC];
	wire       latch_en = ctrl_r[`WTC_C_LATCH];
	wire       mot_en   = ctrl_r[`WTC_C_MOTION];

	// a request still up after its accepting edge starts a new access
	wire       req     = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack_r;               // one wait state
	wire       wr_go   = AVS_WRITE & ack_r;
	wire       start_pulse = start_lvl_r & ~start_lvl_d_r;

	// compared weight
	wire [W-1:0] wt = src_disp ? DISP_WEIGHT : GROSS_WEIGHT;
	wire [W-1:0] ptol = tol_eff(target_r, postol_r, toltype == `WTC_TOL_PCT);
	wire [W-1:0] ntol = tol_eff(target_r, negtol_r, toltype == `WTC_TOL_PCT);
	// zone edges; weight-value type uses limits only
	// a large target plus tolerance must not wrap to a small edge
	wire [W-1:0] hi_edge = (toltype == `WTC_TOL_WV) ? postol_r
	                                                : sat_add(target_r, ptol);
	wire [W-1:0] lo_edge = (toltype == `WTC_TOL_WV) ? negtol_r
	                                                : sat_sub(target_r, ntol);
	// over wins when crossed limits make both tests true, so one zone stands
	wire         is_over  = wt > hi_edge;
	wire         is_under = !is_over && (wt < lo_edge);
	wire         zone_gate = !(mot_en && mot_lvl_r);  // zones only while still
	// material transfer switching points
	wire [W-1:0] stop_pt = sat_sub(target_r, spill_r);
	wire [W-1:0] fast_pt = sat_sub(target_r, fine_r);
	wire         at_stop = wt >= stop_pt;
	wire         at_fast = wt >= fast_pt;
	// feeds held off while latched or at the stop point
	wire         hold_off = latch_r || at_stop;
	wire         fast_cut = at_fast || fast_done_r;

	// input synchronisers: change accepted when stages 2 and 3 agree
	// about four cycles from pin to filtered level
	always @(posedge CORE_CLK) begin
		if (RST) begin
			start_sync_r  <= 3'h0;
			start_lvl_r   <= 1'b0;
			start_lvl_d_r <= 1'b0;
			mot_sync_r    <= 3'h0;
			mot_lvl_r     <= 1'b0;
		end else begin
			start_sync_r  <= {start_sync_r[1:0], START_IN};
			mot_sync_r    <= {mot_sync_r[1:0], MOTION};
			if (start_sync_r[1] == start_sync_r[2])
				start_lvl_r <= start_sync_r[2];
			if (mot_sync_r[1] == mot_sync_r[2])
				mot_lvl_r <= mot_sync_r[2];
			start_lvl_d_r <= start_lvl_r;
		end
	end

	// register writes, table commands
	always @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_r   <= `WTC_CTRL_RST;
			target_r <= {W{1'b0}};
			postol_r <= {W{1'b0}};
			negtol_r <= {W{1'b0}};
			spill_r  <= {W{1'b0}};
			fine_r   <= {W{1'b0}};
			idx_r    <= {TBL_AW{1'b0}};
			sel_r    <= 3'h0;
			ack_r    <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
			if (wr_go) begin
				case (AVS_ADDRESS)
					`WTC_A_CTRL:   ctrl_r   <= be_merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE);
					`WTC_A_TARGET: target_r <= AVS_WRITEDATA[W-1:0];
					`WTC_A_POSTOL: postol_r <= AVS_WRITEDATA[W-1:0];
					`WTC_A_NEGTOL: negtol_r <= AVS_WRITEDATA[W-1:0];
					`WTC_A_SPILL:  spill_r  <= AVS_WRITEDATA[W-1:0];
					`WTC_A_FINE:   fine_r   <= AVS_WRITEDATA[W-1:0];
					`WTC_A_TBL_IDX: begin
						idx_r <= AVS_WRITEDATA[TBL_AW-1:0];
						sel_r <= AVS_WRITEDATA[10:8];
					end
					`WTC_A_CMD: begin
						// recall entry into active record
						if (AVS_WRITEDATA[`WTC_K_RECALL]) begin
							target_r <= tbl_tgt[idx_r];
							postol_r <= tbl_pos[idx_r];
							negtol_r <= tbl_neg[idx_r];
							spill_r  <= tbl_spl[idx_r];
							fine_r   <= tbl_fin[idx_r];
						end
					end
					default: ;
				endcase
			end
		end
	end

	// target table storage; no reset, clear command zeroes all
	// clear outranks store when both command bits are set
	always @(posedge CORE_CLK) begin
		if (wr_go && AVS_ADDRESS == `WTC_A_CMD && AVS_WRITEDATA[`WTC_K_CLEAR]) begin
			for (i = 0; i < TBL_N; i = i + 1) begin
				tbl_tgt[i] <= {W{1'b0}};
				tbl_pos[i] <= {W{1'b0}};
				tbl_neg[i] <= {W{1'b0}};
				tbl_spl[i] <= {W{1'b0}};
				tbl_fin[i] <= {W{1'b0}};
			end
		end else if (wr_go && AVS_ADDRESS == `WTC_A_CMD && AVS_WRITEDATA[`WTC_K_STORE]) begin
			tbl_tgt[idx_r] <= target_r;
			tbl_pos[idx_r] <= postol_r;
			tbl_neg[idx_r] <= negtol_r;
			tbl_spl[idx_r] <= spill_r;
			tbl_fin[idx_r] <= fine_r;
		end else if (wr_go && AVS_ADDRESS == `WTC_A_TBL_DATA) begin
			case (sel_r)
				3'h0: tbl_tgt[idx_r] <= AVS_WRITEDATA[W-1:0];
				3'h1: tbl_pos[idx_r] <= AVS_WRITEDATA[W-1:0];
				3'h2: tbl_neg[idx_r] <= AVS_WRITEDATA[W-1:0];
				3'h3: tbl_spl[idx_r] <= AVS_WRITEDATA[W-1:0];
				default: tbl_fin[idx_r] <= AVS_WRITEDATA[W-1:0];
			endcase
		end
	end

	// read data mux, registered at the wait cycle
	always @(posedge CORE_CLK) begin
		if (RST) begin
			AVS_READDATA <= 32'h0;
		end else if (AVS_READ & ~ack_r) begin
			case (AVS_ADDRESS)
				`WTC_A_CTRL:   AVS_READDATA <= ctrl_r;
				`WTC_A_TARGET: AVS_READDATA <= target_r;
				`WTC_A_POSTOL: AVS_READDATA <= postol_r;
				`WTC_A_NEGTOL: AVS_READDATA <= negtol_r;
				`WTC_A_SPILL:  AVS_READDATA <= spill_r;
				`WTC_A_FINE:   AVS_READDATA <= fine_r;
				`WTC_A_TBL_IDX: AVS_READDATA <= {21'h0, sel_r, 4'h0, idx_r};
				`WTC_A_TBL_DATA: begin
					case (sel_r)
						3'h0: AVS_READDATA <= tbl_tgt[idx_r];
						3'h1: AVS_READDATA <= tbl_pos[idx_r];
						3'h2: AVS_READDATA <= tbl_neg[idx_r];
						3'h3: AVS_READDATA <= tbl_spl[idx_r];
						default: AVS_READDATA <= tbl_fin[idx_r];
					endcase
				end
				`WTC_A_STATUS: AVS_READDATA <= {24'h0, mot_lvl_r, latch_r, fast_done_r,
				                                UNDER_ZONE, TOL_OK, OVER_ZONE,
				                                SLOW_FEED, FAST_FEED};
				default:       AVS_READDATA <= 32'h0;
			endcase
		end
	end

	// latch and fast cutoff state
	always @(posedge CORE_CLK) begin
		if (RST) begin
			latch_r     <= 1'b0;
			fast_done_r <= 1'b0;
		end else if (mode != `WTC_MODE_MT || !latch_en) begin
			latch_r     <= 1'b0;
			fast_done_r <= 1'b0;
		end else if (start_pulse) begin
			// start clears, but a threshold already reached sets again at once
			latch_r     <= at_stop;
			fast_done_r <= at_fast;
		end else begin
			if (at_stop)
				latch_r <= 1'b1;
			if (at_fast)
				fast_done_r <= 1'b1;
		end
	end

	// output stage, all registered
	always @(posedge CORE_CLK) begin
		if (RST) begin
			FAST_FEED  <= 1'b0;
			SLOW_FEED  <= 1'b0;
			OVER_ZONE  <= 1'b0;
			TOL_OK     <= 1'b0;
			UNDER_ZONE <= 1'b0;
		end else begin
			FAST_FEED  <= 1'b0;
			SLOW_FEED  <= 1'b0;
			OVER_ZONE  <= 1'b0;
			TOL_OK     <= 1'b0;
			UNDER_ZONE <= 1'b0;
			case (mode)
				`WTC_MODE_MT: begin
					// held off while latched or at the stop point, else coincidence, or independent when indep is set
					if (!hold_off) begin
						FAST_FEED <= !fast_cut;
						if (indep)
							SLOW_FEED <= fast_cut;
						else
							SLOW_FEED <= 1'b1;
					end
				end
				`WTC_MODE_OU: begin
					if (zone_gate) begin
						OVER_ZONE  <= is_over;
						UNDER_ZONE <= is_under;
						TOL_OK     <= !is_over && !is_under;
					end
				end
				default: ;
			endcase
		end
	end

endmodule

// ==== tb/wtc_props.sv ====
// checker for the comparator outputs and bus handshake
`timescale 1ns/1ps
module wtc_props (
	input logic        CORE_CLK,
	input logic        RST,
	input logic [3:0]  AVS_ADDRESS,
	input logic        AVS_READ,
	input logic        AVS_WRITE,
	input logic [31:0] AVS_WRITEDATA,
	input logic        AVS_WAITREQUEST,
	input logic        MOTION,
	input logic        FAST_FEED,
	input logic        SLOW_FEED,
	input logic        OVER_ZONE,
	input logic        TOL_OK,
	input logic        UNDER_ZONE
);
	logic [7:0] ctrl_r;   // mirror of the control word
	logic [7:0] prev_r;   // control word one cycle back
	wire  [1:0] md = ctrl_r[1:0];
	wire        st = (ctrl_r == prev_r);   // config settled
	wire  [2:0] z  = {OVER_ZONE, TOL_OK, UNDER_ZONE};
	// track accepted control writes
	always @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_r <= 8'h00;
			prev_r <= 8'h00;
		end else begin
			prev_r <= ctrl_r;
			if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0)
				ctrl_r <= AVS_WRITEDATA[7:0];
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	zone_onehot_a: assert property ($onehot0(z)) else $error("zones overlap");
	ou_one_a: assert property (st && md == 2'h2 && !ctrl_r[7] |-> $onehot(z))
		else $error("no single zone");
	none_off_a: assert property (st && md == 2'h0 |-> {FAST_FEED, SLOW_FEED, z} == 5'h00)
		else $error("output in disabled mode");
	feed_mt_a: assert property (st && md != 2'h1 |-> !(FAST_FEED || SLOW_FEED))
		else $error("feed outside transfer");
	zone_ou_a: assert property (st && md != 2'h2 |-> z == 3'h0)
		else $error("zone outside over/under");
	indep_one_a: assert property (st && md == 2'h1 && ctrl_r[4] |-> !(FAST_FEED && SLOW_FEED))
		else $error("both feeds independent");
	conc_both_a: assert property (st && md == 2'h1 && !ctrl_r[4] && FAST_FEED |-> SLOW_FEED)
		else $error("fast without slow");
	motion_gate_a: assert property ((st && md == 2'h2 && ctrl_r[7] && MOTION)[*6] |-> z == 3'h0)
		else $error("zone during motion");
	wait_one_a: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
		else $error("wait state count");
	reset_quiet_a: assert property (disable iff (1'b0) RST |=> {FAST_FEED, SLOW_FEED, z} == 5'h00)
		else $error("output after reset");
	cover property ($fell(FAST_FEED));
	cover property (OVER_ZONE ##1 TOL_OK);
	cover property (ctrl_r[6] && !FAST_FEED ##1 FAST_FEED);
endmodule
bind wtc_top wtc_props u_wtc_props (.CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .MOTION(MOTION), .FAST_FEED(FAST_FEED),
	.SLOW_FEED(SLOW_FEED), .OVER_ZONE(OVER_ZONE), .TOL_OK(TOL_OK), .UNDER_ZONE(UNDER_ZONE));

// ==== tb/wtc_feeder.sv ====
// feeder model: weight grows while feed outputs are on
`timescale 1ns/1ps
module wtc_feeder (
	input  wire        clk,
	input  wire        fast,
	input  wire        slow,
	input  wire        load,
	input  wire [31:0] load_val,
	output reg  [31:0] weight
);
	// fast pours 5, slow 1 unit a cycle, in the target's units
	always @(posedge clk) begin
		if (load)
			weight <= load_val;
		else
			weight <= weight + (fast ? 32'h5 : 32'h0) + (slow ? 32'h1 : 32'h0);
	end
endmodule

// ==== tb/wtc_top_bench.sv ====
// self-checking bench for the weight target comparator
`timescale 1ns/1ps
module wtc_top_bench;
	logic        clk = 0;
	logic        rst = 1;
	logic [3:0]  addr = 0;
	logic        rd_en = 0;
	logic        wr_en = 0;
	logic [31:0] wdata = 0;
	logic [31:0] disp = 0;
	logic        motion = 0;
	logic        start = 0;
	logic        ld = 1;
	logic [31:0] lv = 0;
	logic [31:0] q;
	wire  [31:0] rdata, gross;
	wire         waitreq, fast, slow, over, ok, under;
	int          miscompares = 0, checks = 0, cyc = 0;
	always #5 clk = ~clk;
	wtc_top u_wtc_top (.CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .GROSS_WEIGHT(gross), .DISP_WEIGHT(disp), .MOTION(motion),
		.START_IN(start), .FAST_FEED(fast), .SLOW_FEED(slow), .OVER_ZONE(over), .TOL_OK(ok),
		.UNDER_ZONE(under));
	wtc_feeder u_wtc_feeder (.clk(clk), .fast(fast), .slow(slow), .load(ld), .load_val(lv),
		.weight(gross));
	task end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// one avalon access, held until waitrequest drops
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a; wr_en <= w; rd_en <= !w; wdata <= d;
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		wr_en <= 0; rd_en <= 0;
	endtask
	task regs_t;
		bus(0, 4'h0, 0); chk("ctrl_rst", 0, q);
		bus(1, 4'hf, 32'h5a); bus(0, 4'hf, 0); chk("unmapped", 0, q);
	endtask
	task table_t;
		bus(1, 4'h1, 32'h7b); bus(1, 4'h7, 32'h3); bus(1, 4'h6, 32'h4);
		bus(1, 4'h1, 0); bus(1, 4'h6, 32'h2); bus(0, 4'h1, 0); chk("recall", 32'h7b, q);
		bus(1, 4'h6, 32'h8); bus(1, 4'h6, 32'h2); bus(0, 4'h1, 0); chk("cleared", 0, q);
	endtask
	// fill to target 100, spill 10, fine 30
	task fill(input logic ind, input logic lat);
		int n;
		@(posedge clk); ld <= 1; lv <= 0;
		bus(1, 4'h1, 32'h64); bus(1, 4'h4, 32'ha); bus(1, 4'h5, 32'h1e);
		bus(1, 4'h0, {25'h0, lat, 1'b0, ind, 4'h1});
		@(posedge clk); ld <= 0;
		n = 0;
		while (fast !== 1'b1 && n < 10) begin @(negedge clk); n++; end
		while (fast === 1'b1 && n < 100) begin @(negedge clk); n++; end
		chk("fast_off", 1, gross >= 70 && gross < 82);
		repeat (2) @(negedge clk); chk("slow_on", 1, slow);
		while (slow === 1'b1 && n < 200) begin @(negedge clk); n++; end
		chk("stop_wt", 1, gross >= 90 && gross < 93);
		@(posedge clk); ld <= 1;
		@(posedge clk); ld <= 0;
		repeat (6) @(negedge clk); chk("relatch", !lat, fast);
		if (lat) begin
			@(posedge clk); start <= 1;
			repeat (6) @(posedge clk); start <= 0;
			repeat (6) @(negedge clk); chk("restart", 1, fast);
		end
		bus(1, 4'h0, 0);
	endtask
	// weights 1021, 1020, 970, 969 against each tolerance form
	task zones(input logic [1:0] tt, input logic [31:0] tg, p, ng);
		logic [31:0] wl [4] = '{32'h3fd, 32'h3fc, 32'h3ca, 32'h3c9};
		logic [2:0]  ex [4] = '{3'h4, 3'h2, 3'h2, 3'h1};
		bus(1, 4'h1, tg); bus(1, 4'h2, p); bus(1, 4'h3, ng); bus(1, 4'h0, {28'h0, tt, 2'h2});
		for (int i = 0; i < 4; i++) begin
			@(posedge clk); ld <= 1; lv <= wl[i];
			repeat (3) @(negedge clk); chk("zone", ex[i], {over, ok, under});
		end
	endtask
	task motion_t;
		bus(1, 4'h1, 32'h3e8); bus(1, 4'h2, 32'h14); bus(1, 4'h3, 32'h1e); bus(1, 4'h0, 32'h82);
		@(posedge clk); ld <= 1; lv <= 32'h3e8; motion <= 1;
		repeat (8) @(negedge clk); chk("moving", 0, {over, ok, under});
		@(posedge clk); motion <= 0;
		repeat (8) @(negedge clk); chk("still", 3'h2, {over, ok, under});
		@(posedge clk); lv <= 32'h7d0; disp <= 32'h3e8;
		bus(1, 4'h0, 32'h22); repeat (3) @(negedge clk); chk("disp", 3'h2, {over, ok, under});
		bus(1, 4'h0, 32'h02); repeat (3) @(negedge clk); chk("gross", 3'h4, {over, ok, under});
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		regs_t;
		table_t;
		fill(0, 0);
		fill(1, 0);
		fill(0, 1);
		zones(2'h0, 32'h3e8, 32'h14, 32'h1e);
		zones(2'h1, 32'h3e8, 32'h2, 32'h3);
		zones(2'h2, 32'h5, 32'h3fc, 32'h3ca);
		motion_t;
		end_sim;
	end
endmodule
